//--- rtl/exec_pkg.sv
// shared constants and types for the instruction execution block
package exec_pkg;
   // data and address widths
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int PC_W = 15;
   localparam int OFFSET_W = 9;
   localparam int NIBBLE_W = 4;
   // reset values
   localparam logic [DATA_W-1:0] WORKING_RESET = 8'h00;
   localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
   // destination select encodings
   localparam logic DEST_WORKING = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   // field positions inside the data byte
   localparam int MSB_POS = 7;
   localparam int LSB_POS = 0;
   // cycles spent by a two-cycle instruction
   localparam int LONG_CYCLES = 2;

   // operation selector
   typedef enum logic [2:0] {
      op_no_operation = 3'b000,
      op_add_working_to_file = 3'b001,
      op_add_working_file_with_carry = 3'b010,
      op_arith_shift_right_file = 3'b011,
      op_bit_clear_file = 3'b100,
      op_test_bit_skip_if_clear = 3'b101,
      op_relative_branch = 3'b110
   } op_type;

   // execution state
   typedef enum logic {
      st_execute = 1'b0,
      st_nop = 1'b1
   } state_type;

   // one decoded instruction with its operand byte
   typedef struct packed {
      op_type op;
      logic [ADDR_W-1:0] file_addr;
      logic dest_sel;
      logic [2:0] bit_sel;
      logic [OFFSET_W-1:0] offset;
      logic [DATA_W-1:0] file_data;
   } exec_req_type;

   // status flags
   typedef struct packed {
      logic carry;
      logic digit_carry_flag;
      logic zero;
   } status_type;

   // write toward the data memory file registers
   typedef struct packed {
      logic strobe;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } file_write_type;

   localparam status_type STATUS_RESET = 3'b000;
endpackage

//--- rtl/exec_alu.sv
// combinational arithmetic and bit unit for the execution block
`timescale 1ns/1ns
module exec_alu (
   input wire exec_pkg::op_type op,
   input wire logic [7:0] working,
   input wire logic [7:0] file_data,
   input wire logic carry_in,
   input wire logic [2:0] bit_sel,
   output logic [7:0] result,
   output logic carry_out,
   output logic digit_out,
   output logic zero_out
);
   logic [8:0] full_sum; // sum with carry out of bit seven
   logic [4:0] low_sum; // low nibble sum, carry out of bit three
   logic cin; // carry used by the add

   ////////////////////////////////////////////////////////////////
   // result and flags
   always_comb begin
      cin = (op == exec_pkg::op_add_working_file_with_carry) ? carry_in : 1'b0;
      full_sum = {1'b0, working} + {1'b0, file_data} + {8'h00, cin};
      low_sum = {1'b0, working[3:0]} + {1'b0, file_data[3:0]} + {4'h0, cin};
      result = full_sum[7:0];
      carry_out = full_sum[8];
      digit_out = low_sum[4];
      case (op)
         exec_pkg::op_arith_shift_right_file: begin
            // sign bit is kept, bit zero falls into carry
            result = {file_data[exec_pkg::MSB_POS], file_data[7:1]};
            carry_out = file_data[exec_pkg::LSB_POS];
         end
         exec_pkg::op_bit_clear_file: begin
            result = file_data & ~(8'h01 << bit_sel);
         end
         default: begin
            // add paths keep the sums above
         end
      endcase
      zero_out = (result == 8'h00);
   end
endmodule

//--- rtl/cpu_exec.sv
// execution unit for the add, shift, bit and branch instructions
// Overview of operation
// - add working and file, destination by select
// - add with carry, updates carry digit zero
// - shift right, keep msb, bit zero to carry
// - shift destination by select, only carry zero
// - bit clear zeroes one bit, flags untouched
// - test bit clear skips next, two cycles
// - branch to incremented counter plus signed offset
// - branch always takes two cycles
// - counter change or skip adds nop cycle
`timescale 1ns/1ns
module cpu_exec #(
   parameter int PC_W = exec_pkg::PC_W
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic req_valid,
   input wire exec_pkg::exec_req_type req,
   output logic ready,
   output logic [7:0] working_reg,
   output exec_pkg::status_type status,
   output logic [PC_W-1:0] program_counter,
   output exec_pkg::file_write_type file_write,
   output logic fetch_discard
);
   localparam logic [PC_W-1:0] PC_ONE = {{(PC_W-1){1'b0}}, 1'b1}; // counter step

   exec_pkg::state_type state; // execute or filler nop
   exec_pkg::state_type next_state;
   logic [7:0] next_working_reg;
   exec_pkg::status_type next_status;
   logic [PC_W-1:0] next_program_counter;
   exec_pkg::file_write_type next_file_write;
   logic next_ready;
   logic next_fetch_discard;
   logic [PC_W-1:0] offset_ext; // sign extended branch offset
   logic taken; // request accepted this cycle
   logic [7:0] alu_result;
   logic alu_carry;
   logic alu_digit;
   logic alu_zero;

   ////////////////////////////////////////////////////////////////
   // shared arithmetic unit
   exec_alu u_alu (
      .op(req.op),
      .working(working_reg),
      .file_data(req.file_data),
      .carry_in(status.carry),
      .bit_sel(req.bit_sel),
      .result(alu_result),
      .carry_out(alu_carry),
      .digit_out(alu_digit),
      .zero_out(alu_zero)
   );

   assign offset_ext = {{(PC_W-exec_pkg::OFFSET_W){req.offset[exec_pkg::OFFSET_W-1]}}, req.offset};
   assign taken = req_valid && ready;

   ////////////////////////////////////////////////////////////////
   // next values of the architectural state
   always_comb begin
      next_state = exec_pkg::st_execute;
      next_working_reg = working_reg;
      next_status = status;
      next_program_counter = program_counter;
      next_file_write = file_write;
      next_file_write.strobe = 1'b0; // write is a single pulse
      case (state)
         exec_pkg::st_execute: begin
            if (taken) begin
               next_program_counter = program_counter + PC_ONE;
               case (req.op)
                  exec_pkg::op_add_working_to_file,
                  exec_pkg::op_add_working_file_with_carry: begin
                     if (req.dest_sel == exec_pkg::DEST_FILE) begin
                        next_file_write = {1'b1, req.file_addr, alu_result};
                     end else begin
                        next_working_reg = alu_result;
                     end
                     next_status = {alu_carry, alu_digit, alu_zero};
                  end
                  exec_pkg::op_arith_shift_right_file: begin
                     if (req.dest_sel == exec_pkg::DEST_FILE) begin
                        next_file_write = {1'b1, req.file_addr, alu_result};
                     end else begin
                        next_working_reg = alu_result;
                     end
                     // digit carry is left alone on a shift
                     next_status.carry = alu_carry;
                     next_status.zero = alu_zero;
                  end
                  exec_pkg::op_bit_clear_file: begin
                     next_file_write = {1'b1, req.file_addr, alu_result};
                  end
                  exec_pkg::op_test_bit_skip_if_clear: begin
                     // the already fetched word is stepped over, so the counter moves two
                     if (!req.file_data[req.bit_sel]) begin
                        next_program_counter = program_counter + PC_ONE + PC_ONE;
                        next_state = exec_pkg::st_nop;
                     end
                  end
                  exec_pkg::op_relative_branch: begin
                     next_program_counter = program_counter + PC_ONE + offset_ext;
                     next_state = exec_pkg::st_nop;
                  end
                  default: begin
                     // plain no-operation only advances the counter
                  end
               endcase
            end
         end
         exec_pkg::st_nop: begin
            // filler cycle: requests are refused, nothing changes
            next_state = exec_pkg::st_execute;
         end
         default: begin
            next_state = exec_pkg::st_execute;
         end
      endcase
      next_ready = (next_state == exec_pkg::st_execute);
      next_fetch_discard = (next_state == exec_pkg::st_nop);
   end

   ////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state <= exec_pkg::st_execute;
         working_reg <= exec_pkg::WORKING_RESET;
         status <= exec_pkg::STATUS_RESET;
         program_counter <= exec_pkg::PC_RESET[PC_W-1:0];
         file_write <= '0;
         ready <= 1'b1;
         fetch_discard <= 1'b0;
      end else begin
         state <= next_state;
         working_reg <= next_working_reg;
         status <= next_status;
         program_counter <= next_program_counter;
         file_write <= next_file_write;
         ready <= next_ready;
         fetch_discard <= next_fetch_discard;
      end
   end

   ////////////////////////////////////////////////////////////////
   // checks
   sequence s_filler;
      !ready && fetch_discard ##1 ready && !fetch_discard;
   endsequence

   property p_add_to_working;
      @(posedge clk_sys) disable iff (!rst_b)
      taken && req.op == exec_pkg::op_add_working_to_file && req.dest_sel == exec_pkg::DEST_WORKING
      |=> working_reg == 8'($past(working_reg) + $past(req.file_data)) && status.zero == (working_reg == 8'h00)
          && !file_write.strobe;
   endproperty
   a_add_to_working: assert property (p_add_to_working) else $error("add to working wrong");

   property p_add_to_file;
      @(posedge clk_sys) disable iff (!rst_b)
      taken && req.op == exec_pkg::op_add_working_to_file && req.dest_sel == exec_pkg::DEST_FILE
      |=> file_write.strobe && file_write.addr == $past(req.file_addr)
          && file_write.data == 8'($past(working_reg) + $past(req.file_data)) && $stable(working_reg);
   endproperty
   a_add_to_file: assert property (p_add_to_file) else $error("add to file wrong");

   property p_add_carry;
      @(posedge clk_sys) disable iff (!rst_b)
      taken && req.op == exec_pkg::op_add_working_file_with_carry
      |=> {status.carry, ($past(req.dest_sel) ? file_write.data : working_reg)}
          == 9'({1'b0, $past(working_reg)} + {1'b0, $past(req.file_data)} + {8'h00, $past(status.carry)});
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("add with carry wrong");

   property p_digit_carry;
      @(posedge clk_sys) disable iff (!rst_b)
      taken && req.op == exec_pkg::op_add_working_to_file
      |=> status.digit_carry_flag == ((5'({1'b0, $past(working_reg[3:0])}) + {1'b0, $past(req.file_data[3:0])}) > 5'h0F);
   endproperty
   a_digit_carry: assert property (p_digit_carry) else $error("digit carry wrong");

   property p_shift;
      @(posedge clk_sys) disable iff (!rst_b)
      taken && req.op == exec_pkg::op_arith_shift_right_file && req.dest_sel == exec_pkg::DEST_WORKING
      |=> working_reg == {$past(req.file_data[7]), $past(req.file_data[7:1])}
          && status.carry == $past(req.file_data[0]) && $stable(status.digit_carry_flag);
   endproperty
   a_shift: assert property (p_shift) else $error("shift wrong");

   property p_bit_clear;
      @(posedge clk_sys) disable iff (!rst_b)
      taken && req.op == exec_pkg::op_bit_clear_file
      |=> file_write.strobe && file_write.data == ($past(req.file_data) & ~(8'h01 << $past(req.bit_sel)))
          && $stable(status) && ready;
   endproperty
   a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");

   property p_skip;
      @(posedge clk_sys) disable iff (!rst_b)
      taken && req.op == exec_pkg::op_test_bit_skip_if_clear
      // a sequence cannot sit inside a conditional expression, so the choice is a property if
      |=> if ((($past(req.file_data) >> $past(req.bit_sel)) & 8'h01) == 8'h00) s_filler
          else (ready && !fetch_discard);
   endproperty
   a_skip: assert property (p_skip) else $error("skip timing wrong");

   property p_branch;
      @(posedge clk_sys) disable iff (!rst_b)
      taken && req.op == exec_pkg::op_relative_branch
      |=> program_counter == $past(program_counter) + PC_ONE + $past(offset_ext) && $stable(status)
          ##0 s_filler;
   endproperty
   a_branch: assert property (p_branch) else $error("branch wrong");

   property p_filler_quiet;
      @(posedge clk_sys) disable iff (!rst_b)
      !ready |=> $stable(program_counter) && $stable(working_reg) && !file_write.strobe && ready;
   endproperty
   a_filler_quiet: assert property (p_filler_quiet) else $error("filler cycle not idle");
endmodule

//--- tb/file_mem.sv
// data memory file registers standing beside the execution block
`timescale 1ns/1ns
module file_mem (
   input wire logic clk_sys,
   input wire logic [6:0] addr,
   input wire exec_pkg::file_write_type file_write,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:127]; // file register array
   ////////////////////////////////////////////////////////////////////////////
   // nonzero pattern so that clears and sums show
   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'(i * 37 + 11);
      end
   end
   // forward a write still in flight, or a back-to-back read sees stale data
   assign rd_data = (file_write.strobe && file_write.addr == addr) ? file_write.data : mem[addr];
   // commit the one-cycle write pulse
   always @(posedge clk_sys) begin
      if (file_write.strobe) begin
         mem[file_write.addr] <= file_write.data;
      end
   end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the execution block
`timescale 1ns/1ns
module tb_top;
   logic clk_sys = 1'b0; // system clock
   logic rst_b = 1'b0; // synchronous reset
   logic req_valid = 1'b0; // request present
   exec_pkg::exec_req_type req_drv = '0; // request as driven
   exec_pkg::exec_req_type req_bus; // request with operand byte merged
   logic ready;
   logic [7:0] working_reg;
   exec_pkg::status_type status;
   logic [14:0] program_counter;
   exec_pkg::file_write_type file_write;
   logic fetch_discard;
   logic [7:0] rd_data; // operand byte from the file registers
   logic [43:0] notes [$]; // expected outputs, oldest first
   logic taken = 1'b0; // a request was taken at the last edge
   int mismatches = 0;
   int n_checks = 0;
   int seed = 31679;
   logic [31:0] r; // random draw
   logic [7:0] exp_w = 8'h00; // model working register
   exec_pkg::status_type exp_st = '0; // model flags
   logic [14:0] exp_pc = 15'h0000; // model counter
   exec_pkg::file_write_type exp_fw = '0; // model write port
   logic exp_skip = 1'b0; // model filler cycle
   wire [43:0] seen = {working_reg, status, program_counter, file_write, fetch_discard, ready};
   ////////////////////////////////////////////////////////////////////////////
   // clock and wiring
   always #10 clk_sys = ~clk_sys;
   always_comb begin
      req_bus = req_drv;
      req_bus.file_data = rd_data;
   end
   cpu_exec u_cpu_exec (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid), .req(req_bus),
      .ready(ready), .working_reg(working_reg), .status(status), .program_counter(program_counter),
      .file_write(file_write), .fetch_discard(fetch_discard));
   file_mem u_file_mem (.clk_sys(clk_sys), .addr(req_drv.file_addr), .file_write(file_write),
      .rd_data(rd_data));
   ////////////////////////////////////////////////////////////////////////////
   // comparison and closing
   task automatic cmp(input logic [43:0] got, input logic [43:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end
      else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // driver: waits out the filler cycle, drives, works out the result
   task automatic issue(input logic [2:0] op, input logic [6:0] addr, input logic dsel,
      input logic [2:0] bsel, input logic [8:0] off);
      logic [8:0] sum;
      logic [4:0] dig5;
      logic [7:0] f;
      logic [7:0] res;
      logic cin;
      // a request held over the filler cycle is refused, not taken twice
      for (int i = 0; i < 4 && ready !== 1'b1; i++) begin
         @(negedge clk_sys);
      end
      cmp({43'h0, ready}, 44'h001);
      req_drv.op = exec_pkg::op_type'(op);
      req_drv.file_addr = addr;
      req_drv.dest_sel = dsel;
      req_drv.bit_sel = bsel;
      req_drv.offset = off;
      req_valid = 1'b1;
      #1;
      f = rd_data;
      res = 8'h00;
      cin = (op == 3'h2) ? exp_st.carry : 1'b0;
      exp_fw.strobe = 1'b0;
      exp_skip = 1'b0;
      exp_pc = exp_pc + 15'h0001;
      case (op)
         3'h1, 3'h2: begin
            sum = {1'b0, exp_w} + {1'b0, f} + {8'h00, cin};
            dig5 = {1'b0, exp_w[3:0]} + {1'b0, f[3:0]} + {4'h0, cin};
            res = sum[7:0];
            exp_st = {sum[8], dig5[4], res == 8'h00};
         end
         3'h3: begin
            res = {f[7], f[7:1]};
            exp_st.carry = f[0];
            exp_st.zero = (res == 8'h00);
         end
         3'h4: res = f & ~(8'h01 << bsel);
         3'h5: begin
            exp_skip = ~f[bsel];
            exp_pc = exp_pc + {14'h0000, exp_skip};
         end
         3'h6: begin
            exp_pc = exp_pc + {{6{off[8]}}, off};
            exp_skip = 1'b1;
         end
         default: ;
      endcase
      if (op inside {3'h1, 3'h2, 3'h3} && dsel == exec_pkg::DEST_WORKING) begin
         exp_w = res;
      end
      else if (op inside {3'h1, 3'h2, 3'h3, 3'h4}) begin
         exp_fw = {1'b1, addr, res};
      end
      notes.push_back({exp_w, exp_st, exp_pc, exp_fw, exp_skip, ~exp_skip});
      @(negedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // monitor: one note per taken request, checked once it has landed
   always @(posedge clk_sys) begin
      taken <= rst_b && req_valid && ready;
   end
   always @(negedge clk_sys) begin
      if (taken) begin
         cmp(seen, notes.pop_front());
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // main sequence: reset, every bit cleared then tested, branch extremes, random mix
   initial begin
      repeat (16) @(negedge clk_sys);
      cmp(seen, 44'h001);
      rst_b = 1'b1;
      for (int b = 0; b < 8; b++) begin
         issue(3'h4, 7'(b), 1'b1, 3'(b), 9'h000);
         issue(3'h5, 7'(b), 1'b0, 3'(b), 9'h000);
      end
      issue(3'h6, 7'h00, 1'b0, 3'h0, 9'h100);
      issue(3'h6, 7'h00, 1'b0, 3'h0, 9'h0FF);
      repeat (400) begin
         r = $random(seed);
         if (r[31:29] == 3'h0) begin
            req_valid = 1'b0;
            @(negedge clk_sys);
         end
         issue(r[2:0], r[9:3], r[10], r[13:11], r[22:14]);
      end
      req_valid = 1'b0;
      repeat (3) @(negedge clk_sys);
      complete_run();
   end
   // watchdog far beyond the at most 850 or so cycles the sequence needs
   initial begin
      #200000;
      mismatches++;
      complete_run();
   end
endmodule
